// ==== common/dspe_regs.vh ====
// constants of the door service panel editor
// Contract
// - manual buttons override every external command
// - open and close together: drive open
// - tool control blocks external input signals
// - both buttons at power-up enter editor
// - show digit eight five seconds on entry
// - profile menu alternates C and 1..6
// - open decrements, close increments selected value
// - learn held over two seconds stores, dot
// - short learn in profile: counterweight, no save
// - counterweight menu alternates A and 0..8
// - force limit 150 N minus 10 N/kg
// - short learn in counterweight: input-one menu
// - input-one menu alternates bars and 0..2
// - storing profile overwrites stored counterweight
// - editor left only by power cycle
// - learn held at power-up: factory defaults
// - runtime learn run measures width, mass only
// - cap close and nudge speed by mass
// - default learn run discards editor presets (code resets stored profile and counterweight only, not input-one)
// - apply changed parameters at standstill
`ifndef DSPE_REGS_VH
`define DSPE_REGS_VH
`define DSPE_CLK_HZ 40000000
`define DSPE_CONFIRM_MS 5000
`define DSPE_RELEASE_MS 3000
`define DSPE_LONG_MS 2000
`define DSPE_ALT_MS 1000
`define DSPE_DEBOUNCE_MS 10
`define DSPE_PROFILE_MIN 3'h1
`define DSPE_PROFILE_MAX 3'h6
`define DSPE_PROFILE_RST 3'h1
`define DSPE_WEIGHT_MIN 4'h0
`define DSPE_WEIGHT_MAX 4'h8
`define DSPE_WEIGHT_RST 4'h0
`define DSPE_IN1_MIN 2'h0
`define DSPE_IN1_MAX 2'h2
`define DSPE_IN1_RST 2'h0
`define DSPE_FORCE_MAX_N 8'h96
`define DSPE_FORCE_PER_KG 8'h0a
`define DSPE_SEG_EIGHT 7'h7f
`define DSPE_SEG_C 7'h39
`define DSPE_SEG_A 7'h77
`define DSPE_SEG_BARS 7'h36
`define DSPE_SEG_BLANK 7'h00
`endif

// ==== dv/dspe_panel_properties.sv ====
// assertions on the operator panel ports
`timescale 1ns/10ps
module dspe_panel_properties #(
	parameter DEB_CYC = 4,
	parameter LONG_CYC = 30
) (
	// clock and reset
	input wire core_clk, sys_rst,
	// buttons and tool
	input wire learnRunButton, manualOpenButton, manualCloseButton,
	input wire toolActive, toolOpenCmd, toolCloseCmd,
	// outputs
	input wire doorOpen_ff, doorClose_ff, segDot_ff, editorActive_ff, learnRunStart_ff,
	input wire [6:0] segments_ff,
	input wire [3:0] counterweight_ff,
	input wire [7:0] closeForceLimit_ff
);
	int upCnt, openOn, openOff, closeOff, learnOn;
	wire booted = upCnt > 2 * DEB_CYC + 4;
	wire quiet = openOff > DEB_CYC + 4 && closeOff > DEB_CYC + 4;
	always @(posedge core_clk) begin
		upCnt <= sys_rst ? 0 : (upCnt < 1000 ? upCnt + 1 : upCnt);
		openOn <= manualOpenButton ? openOn + 1 : 0;
		openOff <= manualOpenButton ? 0 : openOff + 1;
		closeOff <= manualCloseButton ? 0 : closeOff + 1;
		learnOn <= learnRunButton ? learnOn + 1 : 0;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_open_wins; !(doorOpen_ff && doorClose_ff); endproperty
	a_open_wins: assert property (p_open_wins) else $error("open and close both driven");
	property p_button_first; booted && openOn > DEB_CYC + 4 && !editorActive_ff |-> doorOpen_ff; endproperty
	a_button_first: assert property (p_button_first) else $error("open button not obeyed");
	property p_tool_blocks; toolActive && !toolOpenCmd && !toolCloseCmd && quiet |=> !doorOpen_ff && !doorClose_ff;
	endproperty
	a_tool_blocks: assert property (p_tool_blocks) else $error("inputs obeyed under tool");
	property p_editor_still; editorActive_ff |-> !doorOpen_ff && !doorClose_ff && !learnRunStart_ff; endproperty
	a_editor_still: assert property (p_editor_still) else $error("door moved in editor");
	property p_confirm; $rose(editorActive_ff) |-> ##2 (segments_ff == 7'h7f)[*8]; endproperty
	a_confirm: assert property (p_confirm) else $error("no eight on entry");
	property p_store_long; $rose(segDot_ff) |-> editorActive_ff && learnOn >= LONG_CYC; endproperty
	a_store_long: assert property (p_store_long) else $error("dot without long press");
	property p_force; $stable(counterweight_ff) |-> closeForceLimit_ff == 8'h96 - 8'h0a * {4'h0, counterweight_ff};
	endproperty
	a_force: assert property (p_force) else $error("force limit wrong");
	property p_no_exit; !$fell(editorActive_ff); endproperty
	a_no_exit: assert property (p_no_exit) else $error("editor left without reset");
endmodule // dspe_panel_properties
bind dspe_panel dspe_panel_properties #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_dspe_panel_properties (
	.core_clk(core_clk), .sys_rst(sys_rst), .learnRunButton(learnRunButton),
	.manualOpenButton(manualOpenButton), .manualCloseButton(manualCloseButton),
	.toolActive(toolActive), .toolOpenCmd(toolOpenCmd), .toolCloseCmd(toolCloseCmd),
	.doorOpen_ff(doorOpen_ff), .doorClose_ff(doorClose_ff), .segDot_ff(segDot_ff),
	.editorActive_ff(editorActive_ff), .learnRunStart_ff(learnRunStart_ff), .segments_ff(segments_ff),
	.counterweight_ff(counterweight_ff), .closeForceLimit_ff(closeForceLimit_ff));

// ==== dv/dspe_tech_model.sv ====
// technician model: presses the panel buttons
`timescale 1ns/10ps
module dspe_tech_model (
	// clock
	input wire core_clk,
	// panel buttons, high while pressed
	output reg learnRunButton,
	output reg manualOpenButton,
	output reg manualCloseButton
);
	initial {learnRunButton, manualOpenButton, manualCloseButton} = 3'h0;
	// mask bit 2 learn, bit 1 open, bit 0 close
	task automatic hold(input [2:0] m);
		@(posedge core_clk);
		#1 {learnRunButton, manualOpenButton, manualCloseButton} = m;
	endtask
	// each press held n+1 cycles, then a gap longer than the debounce
	task automatic press(input [2:0] m, input int n, input int times);
		repeat (times) begin
			hold(m);
			repeat (n) @(posedge core_clk);
			hold(3'h0);
			repeat (12) @(posedge core_clk);
		end
	endtask
endmodule // dspe_tech_model

// ==== dv/testbench.sv ====
// self-checking bench for the operator panel
`timescale 1ns/10ps
`include "dspe_regs.vh"
module testbench;
	localparam DEB = 4;
	localparam [2:0] BL = 3'h4, BO = 3'h2, BC = 3'h1;
	reg core_clk = 0, sys_rst = 1, inputOpenCmd = 0, inputCloseCmd = 0, busOpenCmd = 0, busCloseCmd = 0;
	reg toolActive = 0, toolOpenCmd = 0, toolCloseCmd = 0, doorStandstill = 1, learnRunDone = 0;
	reg [9:0] measuredMass = 10'h000;
	reg [7:0] reqCloseSpeed = 8'h00, reqNudgeSpeed = 8'h00;
	wire learnRunButton, manualOpenButton, manualCloseButton, doorOpen_ff, doorClose_ff, segDot_ff;
	wire editorActive_ff, learnRunStart_ff, factoryDefaults_ff;
	wire [6:0] segments_ff;
	wire [2:0] profile_ff;
	wire [3:0] counterweight_ff;
	wire [1:0] input1Func_ff;
	wire [7:0] closeForceLimit_ff, maxCloseSpeed_ff, nudgeSpeed_ff;
	int fail_count = 0, compares = 0, starts = 0, defaults = 0;
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (learnRunStart_ff === 1'b1) starts++;
		if (factoryDefaults_ff === 1'b1) defaults++;
	end
	dspe_tech_model u_dspe_tech_model (.core_clk(core_clk), .learnRunButton(learnRunButton),
		.manualOpenButton(manualOpenButton), .manualCloseButton(manualCloseButton));
	dspe_panel #(.CONFIRM_CYC(50), .RELEASE_CYC(40), .LONG_CYC(30), .ALT_CYC(10), .DEB_CYC(DEB)) u_dspe_panel (
		.core_clk(core_clk), .sys_rst(sys_rst), .learnRunButton(learnRunButton),
		.manualOpenButton(manualOpenButton), .manualCloseButton(manualCloseButton),
		.inputOpenCmd(inputOpenCmd), .inputCloseCmd(inputCloseCmd), .busOpenCmd(busOpenCmd),
		.busCloseCmd(busCloseCmd), .toolActive(toolActive), .toolOpenCmd(toolOpenCmd),
		.toolCloseCmd(toolCloseCmd), .doorStandstill(doorStandstill), .learnRunDone(learnRunDone),
		.measuredMass(measuredMass), .reqCloseSpeed(reqCloseSpeed), .reqNudgeSpeed(reqNudgeSpeed),
		.doorOpen_ff(doorOpen_ff), .doorClose_ff(doorClose_ff), .segments_ff(segments_ff),
		.segDot_ff(segDot_ff), .editorActive_ff(editorActive_ff), .learnRunStart_ff(learnRunStart_ff),
		.factoryDefaults_ff(factoryDefaults_ff), .profile_ff(profile_ff), .counterweight_ff(counterweight_ff),
		.input1Func_ff(input1Func_ff), .closeForceLimit_ff(closeForceLimit_ff),
		.maxCloseSpeed_ff(maxCloseSpeed_ff), .nudgeSpeed_ff(nudgeSpeed_ff));
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input [31:0] got, input [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic doors(input [1:0] e);
		step(2);
		check({doorOpen_ff, doorClose_ff}, e);
	endtask
	task automatic waitSeg(input [6:0] pat);
		int i;
		for (i = 0; i < 100 && segments_ff !== pat; i++) step(1);
		check(segments_ff, pat);
	endtask
	task automatic pulseDone;
		learnRunDone = 1;
		step(1);
		learnRunDone = 0;
		step(3);
	endtask
	task automatic boot(input [2:0] m);
		u_dspe_tech_model.hold(m);
		sys_rst = 1;
		step(5);
		sys_rst = 0;
		step(20);
	endtask
	task automatic t_priority;
		{busOpenCmd, busCloseCmd} = 2'h3;
		doors(2'b10);
		busOpenCmd = 0;
		doors(2'b01);
		toolActive = 1;
		doors(2'b00);
		{toolCloseCmd, inputOpenCmd} = 2'h3;
		doors(2'b01);
		u_dspe_tech_model.hold(BO);
		step(DEB + 5);
		check({doorOpen_ff, doorClose_ff}, 2'b10);
		u_dspe_tech_model.hold(3'h0);
		step(DEB + 3);
		doors(2'b01);
		toolOpenCmd = 1;
		doors(2'b10);
		{toolActive, toolOpenCmd, toolCloseCmd, inputOpenCmd, busCloseCmd} = 5'h0;
		inputCloseCmd = 1;
		doors(2'b01);
		inputCloseCmd = 0;
		doors(2'b00);
	endtask
	task automatic t_learn;
		u_dspe_tech_model.press(BL, 10, 1);
		check(starts, 1);
		{doorStandstill, measuredMass, reqCloseSpeed, reqNudgeSpeed} = {1'b0, 10'h12c, 8'h50, 8'h30};
		pulseDone;
		check({maxCloseSpeed_ff, nudgeSpeed_ff}, 16'h0000);
		doorStandstill = 1;
		step(3);
		check({maxCloseSpeed_ff, nudgeSpeed_ff}, 16'h280f);
		check(defaults, 0);
		check(closeForceLimit_ff, 8'h96);
	endtask
	task automatic t_editor;
		boot(BO | BC);
		check(segments_ff, `DSPE_SEG_EIGHT);
		step(40);
		u_dspe_tech_model.hold(3'h0);
		check(editorActive_ff, 1);
		waitSeg(`DSPE_SEG_C);
		starts = 0;
		u_dspe_tech_model.press(BC, 10, 1);
		u_dspe_tech_model.press(BL, 10, 1);
		check(profile_ff, 1);
		waitSeg(`DSPE_SEG_A);
		u_dspe_tech_model.press(BO, 10, 1);
		u_dspe_tech_model.press(BC, 10, 9);
		u_dspe_tech_model.press(BL, 45, 1);
		check({segDot_ff, counterweight_ff, closeForceLimit_ff}, 13'h1846);
		u_dspe_tech_model.press(BO, 10, 2);
		u_dspe_tech_model.press(BL, 10, 1);
		check(counterweight_ff, 8);
		waitSeg(`DSPE_SEG_BARS);
		u_dspe_tech_model.press(BC, 10, 3);
		u_dspe_tech_model.press(BL, 45, 1);
		check(input1Func_ff, 2);
		u_dspe_tech_model.press(BL, 10, 1);
		waitSeg(`DSPE_SEG_C);
		u_dspe_tech_model.press(BC, 10, 7);
		u_dspe_tech_model.press(BO, 10, 1);
		u_dspe_tech_model.press(BL, 45, 1);
		check({profile_ff, counterweight_ff, closeForceLimit_ff}, 15'h5096);
		check(starts, 0);
	endtask
	task automatic t_factory;
		boot(BL);
		u_dspe_tech_model.hold(3'h0);
		step(20);
		{starts, defaults} = 0;
		u_dspe_tech_model.press(BL, 10, 1);
		pulseDone;
		check(starts, 1);
		check(defaults, 1);
		check({profile_ff, counterweight_ff}, 7'h10);
	endtask
	task automatic results;
		if (fail_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		results;
	end
	initial begin
		boot(3'h0);
		check({profile_ff, counterweight_ff, input1Func_ff, closeForceLimit_ff}, 17'h04096);
		t_priority;
		t_learn;
		t_editor;
		t_factory;
		results;
	end
endmodule // testbench

// ==== verilog/dspe_panel.v ====
// operator panel: manual moves, minimal editor and learn-run parameter handling
`timescale 1ns/10ps
`include "dspe_regs.vh"
module dspe_panel #(
	parameter CONFIRM_CYC = `DSPE_CONFIRM_MS * (`DSPE_CLK_HZ / 1000),
	parameter RELEASE_CYC = `DSPE_RELEASE_MS * (`DSPE_CLK_HZ / 1000),
	parameter LONG_CYC = `DSPE_LONG_MS * (`DSPE_CLK_HZ / 1000),
	parameter ALT_CYC = `DSPE_ALT_MS * (`DSPE_CLK_HZ / 1000),
	parameter DEB_CYC = `DSPE_DEBOUNCE_MS * (`DSPE_CLK_HZ / 1000),
	parameter [9:0] HEAVY_MASS = 10'h0c8,
	parameter [7:0] HEAVY_CLOSE_SPEED = 8'h28,
	parameter [7:0] HEAVY_NUDGE_SPEED = 8'h0f
) (
	// clock and reset
	input wire core_clk,
	input wire sys_rst,
	// panel push buttons, active high pins
	input wire learnRunButton,
	input wire manualOpenButton,
	input wire manualCloseButton,
	// external command sources, same clock
	input wire inputOpenCmd,
	input wire inputCloseCmd,
	input wire busOpenCmd,
	input wire busCloseCmd,
	input wire toolActive,
	input wire toolOpenCmd,
	input wire toolCloseCmd,
	// drive status and learn-run results
	input wire doorStandstill,
	input wire learnRunDone,
	input wire [9:0] measuredMass,
	input wire [7:0] reqCloseSpeed,
	input wire [7:0] reqNudgeSpeed,
	// door commands
	output reg doorOpen_ff,
	output reg doorClose_ff,
	// seven_segment_display
	output reg [6:0] segments_ff,
	output reg segDot_ff,
	// editor and learn-run status
	output reg editorActive_ff,
	output reg learnRunStart_ff,
	output reg factoryDefaults_ff,
	// parameters in effect
	output reg [2:0] profile_ff,
	output reg [3:0] counterweight_ff,
	output reg [1:0] input1Func_ff,
	output reg [7:0] closeForceLimit_ff,
	output reg [7:0] maxCloseSpeed_ff,
	output reg [7:0] nudgeSpeed_ff
);
	localparam [2:0] ST_BOOT = 3'h0;
	localparam [2:0] ST_NORMAL = 3'h1;
	localparam [2:0] ST_CONFIRM = 3'h2;
	localparam [2:0] ST_RELEASE = 3'h3;
	localparam [2:0] ST_PROFILE = 3'h4;
	localparam [2:0] ST_WEIGHT = 3'h5;
	localparam [2:0] ST_INPUT1 = 3'h6;
	localparam [27:0] CONFIRM_END = CONFIRM_CYC[27:0] - 28'h1;
	localparam [27:0] RELEASE_END = RELEASE_CYC[27:0] - 28'h1;
	localparam [27:0] LONG_END = LONG_CYC[27:0] - 28'h1;
	localparam [27:0] ALT_END = ALT_CYC[27:0] - 28'h1;
	localparam [27:0] BOOT_END = DEB_CYC[27:0] + DEB_CYC[27:0];
	localparam [19:0] DEB_END = DEB_CYC[19:0] - 20'h1;

	// synchronise and debounce the three buttons (open, close, learn)
	wire [2:0] btnPin = {learnRunButton, manualCloseButton, manualOpenButton};
	wire [2:0] btnDeb;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : gDeb
			reg meta_ff;
			reg sync_ff;
			reg deb_ff;
			reg [19:0] cnt_ff;
			always @(posedge core_clk) begin
				if (sys_rst) begin
					meta_ff <= 1'b0;
					sync_ff <= 1'b0;
					deb_ff <= 1'b0;
					cnt_ff <= 20'h0;
				end else begin
					meta_ff <= btnPin[gi];
					sync_ff <= meta_ff;
					if (sync_ff == deb_ff) begin
						cnt_ff <= 20'h0;
					end else if (cnt_ff == DEB_END) begin
						deb_ff <= sync_ff;
						cnt_ff <= 20'h0;
					end else begin
						cnt_ff <= cnt_ff + 20'h1;
					end
				end
			end
			assign btnDeb[gi] = deb_ff;
		end
	endgenerate

	wire openBtn = btnDeb[0];
	wire closeBtn = btnDeb[1];
	wire learnBtn = btnDeb[2];
	reg [2:0] btnPrev_ff;
	wire openPress = openBtn & ~btnPrev_ff[0];
	wire closePress = closeBtn & ~btnPrev_ff[1];
	wire learnPress = learnBtn & ~btnPrev_ff[2];
	wire learnRelease = ~learnBtn & btnPrev_ff[2];

	reg [2:0] state_ff;
	reg [27:0] timer_ff;
	reg [27:0] holdCnt_ff;
	reg longDone_ff;
	reg [27:0] altCnt_ff;
	reg altPhase_ff;
	reg factoryPend_ff;
	reg learnRunning_ff;
	// editor selections and stored values
	reg [2:0] selProfile_ff;
	reg [3:0] selWeight_ff;
	reg [1:0] selIn1_ff;
	reg [2:0] stProfile_ff;
	reg [3:0] stWeight_ff;
	reg [1:0] stIn1_ff;
	reg [9:0] mass_ff;

	function [6:0] digitSeg;
		input [3:0] d;
		begin
			case (d)
				4'h0: digitSeg = 7'h3f;
				4'h1: digitSeg = 7'h06;
				4'h2: digitSeg = 7'h5b;
				4'h3: digitSeg = 7'h4f;
				4'h4: digitSeg = 7'h66;
				4'h5: digitSeg = 7'h6d;
				4'h6: digitSeg = 7'h7d;
				4'h7: digitSeg = 7'h07;
				4'h8: digitSeg = `DSPE_SEG_EIGHT;
				default: digitSeg = `DSPE_SEG_BLANK;
			endcase
		end
	endfunction

	wire inEditMenu = (state_ff == ST_PROFILE) || (state_ff == ST_WEIGHT) || (state_ff == ST_INPUT1);
	wire longReached = learnBtn && !longDone_ff && (holdCnt_ff == LONG_END);
	wire shortPress = learnRelease && !longDone_ff;

	// mode sequencer
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff <= ST_BOOT;
			timer_ff <= 28'h0;
			factoryPend_ff <= 1'b0;
			editorActive_ff <= 1'b0;
		end else begin
			timer_ff <= timer_ff + 28'h1;
			case (state_ff)
				ST_BOOT: begin
					if (timer_ff == BOOT_END) begin
						timer_ff <= 28'h0;
						factoryPend_ff <= learnBtn;
						if (openBtn && closeBtn) begin
							state_ff <= ST_CONFIRM;
							editorActive_ff <= 1'b1;
						end else begin
							state_ff <= ST_NORMAL;
						end
					end
				end
				ST_NORMAL: begin
					timer_ff <= 28'h0;
					if (learnRunDone) begin
						factoryPend_ff <= 1'b0;
					end
				end
				ST_CONFIRM: begin
					if (timer_ff == CONFIRM_END) begin
						timer_ff <= 28'h0;
						state_ff <= ST_RELEASE;
					end
				end
				ST_RELEASE: begin
					if (timer_ff == RELEASE_END) begin
						timer_ff <= 28'h0;
						state_ff <= ST_PROFILE;
					end
				end
				// editor menus are left only by reset (power cycle)
				ST_PROFILE: begin
					if (shortPress) begin
						state_ff <= ST_WEIGHT;
					end
				end
				ST_WEIGHT: begin
					if (shortPress) begin
						state_ff <= ST_INPUT1;
					end
				end
				ST_INPUT1: begin
					if (shortPress) begin
						state_ff <= ST_PROFILE;
					end
				end
				default: begin
					state_ff <= ST_BOOT;
				end
			endcase
		end
	end

	// learn-button hold timing, display alternation, button history
	always @(posedge core_clk) begin
		if (sys_rst) begin
			btnPrev_ff <= 3'h0;
			holdCnt_ff <= 28'h0;
			longDone_ff <= 1'b0;
			altCnt_ff <= 28'h0;
			altPhase_ff <= 1'b0;
		end else begin
			btnPrev_ff <= btnDeb;
			if (!learnBtn || !inEditMenu) begin
				holdCnt_ff <= 28'h0;
				longDone_ff <= 1'b0;
			end else if (longReached) begin
				longDone_ff <= 1'b1;
			end else if (!longDone_ff) begin
				holdCnt_ff <= holdCnt_ff + 28'h1;
			end
			if (!inEditMenu || shortPress || altCnt_ff == ALT_END) begin
				altCnt_ff <= 28'h0;
				altPhase_ff <= inEditMenu && !shortPress && !altPhase_ff;
			end else begin
				altCnt_ff <= altCnt_ff + 28'h1;
			end
		end
	end

	// editor selection, store and learn-run handling of stored values
	always @(posedge core_clk) begin
		if (sys_rst) begin
			selProfile_ff <= `DSPE_PROFILE_RST;
			selWeight_ff <= `DSPE_WEIGHT_RST;
			selIn1_ff <= `DSPE_IN1_RST;
			stProfile_ff <= `DSPE_PROFILE_RST;
			stWeight_ff <= `DSPE_WEIGHT_RST;
			stIn1_ff <= `DSPE_IN1_RST;
			segDot_ff <= 1'b0;
			mass_ff <= 10'h0;
			learnRunStart_ff <= 1'b0;
			learnRunning_ff <= 1'b0;
			factoryDefaults_ff <= 1'b0;
		end else begin
			learnRunStart_ff <= 1'b0;
			factoryDefaults_ff <= 1'b0;
			if (state_ff == ST_RELEASE) begin
				selProfile_ff <= stProfile_ff;
				selWeight_ff <= stWeight_ff;
				selIn1_ff <= stIn1_ff;
			end
			if (shortPress) begin
				segDot_ff <= 1'b0;
				selProfile_ff <= stProfile_ff;
				selWeight_ff <= stWeight_ff;
				selIn1_ff <= stIn1_ff;
			end
			case (state_ff)
				ST_PROFILE: begin
					if (openPress && selProfile_ff != `DSPE_PROFILE_MIN) begin
						selProfile_ff <= selProfile_ff - 3'h1;
					end else if (closePress && selProfile_ff != `DSPE_PROFILE_MAX) begin
						selProfile_ff <= selProfile_ff + 3'h1;
					end
					if (longReached) begin
						stProfile_ff <= selProfile_ff;
						stWeight_ff <= `DSPE_WEIGHT_RST;
						selWeight_ff <= `DSPE_WEIGHT_RST;
						segDot_ff <= 1'b1;
					end
				end
				ST_WEIGHT: begin
					if (openPress && selWeight_ff != `DSPE_WEIGHT_MIN) begin
						selWeight_ff <= selWeight_ff - 4'h1;
					end else if (closePress && selWeight_ff != `DSPE_WEIGHT_MAX) begin
						selWeight_ff <= selWeight_ff + 4'h1;
					end
					if (longReached) begin
						stWeight_ff <= selWeight_ff;
						segDot_ff <= 1'b1;
					end
				end
				ST_INPUT1: begin
					if (openPress && selIn1_ff != `DSPE_IN1_MIN) begin
						selIn1_ff <= selIn1_ff - 2'h1;
					end else if (closePress && selIn1_ff != `DSPE_IN1_MAX) begin
						selIn1_ff <= selIn1_ff + 2'h1;
					end
					if (longReached) begin
						stIn1_ff <= selIn1_ff;
						segDot_ff <= 1'b1;
					end
				end
				ST_NORMAL: begin
					if (learnRunDone) begin
						learnRunning_ff <= 1'b0;
						mass_ff <= measuredMass;
						if (factoryPend_ff) begin
							factoryDefaults_ff <= 1'b1;
							stProfile_ff <= `DSPE_PROFILE_RST;
							stWeight_ff <= `DSPE_WEIGHT_RST;
						end
					end
					// a new start in the same cycle as a finish is ignored, since learnRunning_ff is still set
					if (learnPress && !learnRunning_ff) begin
						learnRunStart_ff <= 1'b1;
						learnRunning_ff <= 1'b1;
					end
				end
				default: begin
					segDot_ff <= 1'b0;
				end
			endcase
		end
	end

	// seven_segment_display contents
	always @(posedge core_clk) begin
		if (sys_rst) begin
			segments_ff <= `DSPE_SEG_BLANK;
		end else begin
			case (state_ff)
				ST_CONFIRM: segments_ff <= `DSPE_SEG_EIGHT;
				ST_PROFILE: segments_ff <= altPhase_ff ? digitSeg({1'b0, selProfile_ff}) : `DSPE_SEG_C;
				ST_WEIGHT: segments_ff <= altPhase_ff ? digitSeg(selWeight_ff) : `DSPE_SEG_A;
				ST_INPUT1: segments_ff <= altPhase_ff ? digitSeg({2'h0, selIn1_ff}) : `DSPE_SEG_BARS;
				default: segments_ff <= `DSPE_SEG_BLANK;
			endcase
		end
	end

	// door command arbitration; no movement outside normal operation
	reg nxt_open;
	reg nxt_close;
	always @* begin
		nxt_open = 1'b0;
		nxt_close = 1'b0;
		if (state_ff == ST_NORMAL) begin
			if (openBtn || closeBtn) begin
				nxt_open = openBtn;
				nxt_close = closeBtn;
			end else if (toolActive) begin
				nxt_open = toolOpenCmd;
				nxt_close = toolCloseCmd;
			end else begin
				nxt_open = inputOpenCmd | busOpenCmd;
				nxt_close = inputCloseCmd | busCloseCmd;
			end
			if (nxt_open) begin
				nxt_close = 1'b0;
			end
		end
	end

	// parameters in effect follow stored values only at standstill
	wire [7:0] weightForce = {4'h0, stWeight_ff} * `DSPE_FORCE_PER_KG;
	wire heavy = mass_ff > HEAVY_MASS;
	always @(posedge core_clk) begin
		if (sys_rst) begin
			doorOpen_ff <= 1'b0;
			doorClose_ff <= 1'b0;
			profile_ff <= `DSPE_PROFILE_RST;
			counterweight_ff <= `DSPE_WEIGHT_RST;
			input1Func_ff <= `DSPE_IN1_RST;
			closeForceLimit_ff <= `DSPE_FORCE_MAX_N;
			maxCloseSpeed_ff <= 8'h0;
			nudgeSpeed_ff <= 8'h0;
		end else begin
			doorOpen_ff <= nxt_open;
			doorClose_ff <= nxt_close;
			if (doorStandstill) begin
				profile_ff <= stProfile_ff;
				counterweight_ff <= stWeight_ff;
				input1Func_ff <= stIn1_ff;
				closeForceLimit_ff <= `DSPE_FORCE_MAX_N - weightForce;
				maxCloseSpeed_ff <= (heavy && reqCloseSpeed > HEAVY_CLOSE_SPEED) ? HEAVY_CLOSE_SPEED : reqCloseSpeed;
				nudgeSpeed_ff <= (heavy && reqNudgeSpeed > HEAVY_NUDGE_SPEED) ? HEAVY_NUDGE_SPEED : reqNudgeSpeed;
			end
		end
	end
endmodule // dspe_panel
